/* File: src/uws_pkg.sv */
// constants, field layout and types of the upstream window setup registers
// assumes one bridge core clock; shared by the register bank, the bench and the checker
package uws_pkg;

  localparam int          UWS_ADDR_W      = 8;
  localparam int          UWS_DATA_W      = 32;
  localparam int          UWS_STRB_W      = 4;

  // register byte offsets
  localparam logic [7:0]  OFF_MEM0_TB     = 8'hE0;
  localparam logic [7:0]  OFF_MEM0_SETUP  = 8'hE4;
  localparam logic [7:0]  OFF_WIN1_TB     = 8'hE8;
  localparam logic [7:0]  OFF_WIN1_SETUP  = 8'hEC;
  localparam logic [7:0]  OFF_CAP_HDR     = 8'hF0;
  localparam logic [7:0]  OFF_MEM0_BASE   = 8'h10;
  localparam logic [7:0]  OFF_WIN1_BASE   = 8'h14;

  // setup register fields
  localparam int          SETUP_TYPE_BIT  = 0;
  localparam int          SETUP_AT_LSB    = 1;
  localparam int          SETUP_AT_MSB    = 2;
  localparam int          SETUP_PF_BIT    = 3;
  localparam int          SETUP_MASK_MSB  = 30;
  localparam int          SETUP_EN_BIT    = 31;
  localparam int          MEM0_LOW_W      = 12;
  localparam int          WIN1_LOW_W      = 6;
  localparam int          MEM0_MASK_W     = SETUP_MASK_MSB - MEM0_LOW_W + 1;
  localparam int          WIN1_MASK_W     = SETUP_MASK_MSB - WIN1_LOW_W + 1;

  localparam logic [1:0]  AT_32BIT        = 2'h0;
  localparam logic [1:0]  AT_64BIT        = 2'h1;
  localparam logic        TYPE_MEMORY     = 1'b0;

  // reset values
  localparam logic [1:0]  AT_RST          = 2'h0;
  localparam logic        PF_RST          = 1'b0;
  localparam logic        MEM0_EN_VALUE   = 1'b1;
  localparam logic        WIN1_EN_RST     = 1'b0;
  localparam logic [31:0] TB_RST          = 32'h0000_0000;
  localparam logic [31:0] MEM0_BASE_RST   = 32'hFFFF_F000;
  localparam logic [31:0] WIN1_BASE_RST   = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;

  // capability header
  localparam logic [7:0]  CAP_ID_MSI      = 8'h05;
  localparam logic [7:0]  CAP_NEXT_END    = 8'h00;
  localparam logic [15:0] CAP_HDR_HI      = 16'h0000;

  // bus responses
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef enum logic {
    UWS_LOAD_MEM0,
    UWS_LOAD_WIN1
  } uws_load_sel_t;

endpackage

/* File: src/uws_regs.sv */
// upstream window setup register bank with address decode and translation
// assumes AXI4-Lite master, load path and upstream requests on clock
//
// Overview of operation
// - type selector bit 0 always reads zero
// - address type and prefetch fields, reset zero
// - mask zero makes base bit read-only
// - mask one makes base bit writable
// - memory 0 enable stays one always
// - default memory 0 base reads FFFFF000h
// - window 1 translated base bits 31:6
// - masked bits translated, lower bits pass
// - window 1 enable bit, reset disabled
// - capability identifier reads 05h
// - next capability pointer reads 00h
// - memory 0 translated base bits 31:12
`timescale 1ns/100ps

module uws_regs
  import uws_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic [UWS_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [UWS_DATA_W-1:0] s_axi_wdata,
  input  wire logic [UWS_STRB_W-1:0] s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [UWS_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [UWS_DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  setup_load_writable,
  input  wire uws_load_sel_t         setup_load_sel,
  input  wire logic [UWS_DATA_W-1:0] setup_load_data,
  input  wire logic                  up_valid,
  input  wire logic [UWS_DATA_W-1:0] up_addr,
  output logic                       fwd_valid,
  output logic [UWS_DATA_W-1:0]      fwd_addr,
  output logic                       fwd_hit_mem0,
  output logic                       fwd_hit_win1
);

  // setup state
  logic [1:0]             mem0_at;
  logic                   mem0_pf;
  logic [MEM0_MASK_W-1:0] mem0_mask;
  logic [1:0]             win1_at;
  logic                   win1_pf;
  logic [WIN1_MASK_W-1:0] win1_mask;
  logic                   win1_en;

  // software state
  logic [31:0]            mem0_tb;
  logic [31:0]            win1_tb;
  logic [31:0]            mem0_base;
  logic [31:0]            win1_base;

  // bus holding state
  logic [UWS_ADDR_W-1:0]  wr_addr;
  logic [UWS_DATA_W-1:0]  wr_data;
  logic [UWS_STRB_W-1:0]  wr_strb;
  logic                   aw_held;
  logic                   w_held;
  logic                   next_aw_held;
  logic                   next_w_held;
  logic                   next_rvalid;
  logic                   do_write;
  logic                   rd_take;

  // derived masks
  logic [31:0]            mem0_cmask;
  logic [31:0]            win1_cmask;
  logic [31:0]            mem0_tb_wmask;
  logic [31:0]            win1_tb_wmask;
  logic [31:0]            mem0_setup_word;
  logic [31:0]            win1_setup_word;
  logic [31:0]            rd_word;
  logic                   hit0;
  logic                   hit1;

  function automatic logic addr_known(input logic [UWS_ADDR_W-1:0] a);
    logic k;
    k = 1'b0;
    if (a == OFF_MEM0_TB) begin
      k = 1'b1;
    end else if (a == OFF_MEM0_SETUP) begin
      k = 1'b1;
    end else if (a == OFF_WIN1_TB) begin
      k = 1'b1;
    end else if (a == OFF_WIN1_SETUP) begin
      k = 1'b1;
    end else if (a == OFF_CAP_HDR) begin
      k = 1'b1;
    end else if (a == OFF_MEM0_BASE) begin
      k = 1'b1;
    end else if (a == OFF_WIN1_BASE) begin
      k = 1'b1;
    end
    return k;
  endfunction

  // byte-lane merge limited to the writable bits
  function automatic logic [31:0] lane_merge(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0]  strb,
    input logic [31:0] wmask
  );
    logic [31:0] m;
    m = old;
    for (int b = 0; b < UWS_STRB_W; b++) begin
      if (strb[b]) begin
        m[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return (old & ~wmask) | (m & wmask);
  endfunction

  // window compare on the bits the mask selects
  function automatic logic win_match(
    input logic [31:0] addr,
    input logic [31:0] base,
    input logic [31:0] cmask
  );
    return ((addr ^ base) & cmask) == ZERO_WORD;
  endfunction

  // translated bits replace the compared ones
  function automatic logic [31:0] win_xlate(
    input logic [31:0] addr,
    input logic [31:0] tb,
    input logic [31:0] cmask
  );
    return (addr & ~cmask) | (tb & cmask);
  endfunction

  assign mem0_cmask = {1'b1, mem0_mask, {MEM0_LOW_W{1'b0}}};
  assign win1_cmask = {1'b1, win1_mask, {WIN1_LOW_W{1'b0}}};

  // memory 0 translated base low bits zero
  assign mem0_tb_wmask = {{(UWS_DATA_W-MEM0_LOW_W){1'b1}},
                          {MEM0_LOW_W{1'b0}}};
  // window 1 translated base low bits zero
  assign win1_tb_wmask = {{(UWS_DATA_W-WIN1_LOW_W){1'b1}},
                          {WIN1_LOW_W{1'b0}}};

  assign mem0_setup_word = {MEM0_EN_VALUE, mem0_mask,
                            {(MEM0_LOW_W-SETUP_PF_BIT-1){1'b0}},
                            mem0_pf, mem0_at, TYPE_MEMORY};
  // window 1 enable in top bit
  assign win1_setup_word = {win1_en, win1_mask,
                            {(WIN1_LOW_W-SETUP_PF_BIT-1){1'b0}},
                            win1_pf, win1_at, TYPE_MEMORY};

  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign rd_take  = s_axi_arvalid && s_axi_arready;

  // read decode
  always_comb begin
    rd_word = ZERO_WORD;
    if (s_axi_araddr == OFF_MEM0_TB) begin
      rd_word = mem0_tb;
    end else if (s_axi_araddr == OFF_MEM0_SETUP) begin
      rd_word = mem0_setup_word;
    end else if (s_axi_araddr == OFF_WIN1_TB) begin
      rd_word = win1_tb;
    end else if (s_axi_araddr == OFF_WIN1_SETUP) begin
      rd_word = win1_setup_word;
    end else if (s_axi_araddr == OFF_CAP_HDR) begin
      rd_word = {CAP_HDR_HI, CAP_NEXT_END, CAP_ID_MSI};
    end else if (s_axi_araddr == OFF_MEM0_BASE) begin
      rd_word = mem0_base;
    end else if (s_axi_araddr == OFF_WIN1_BASE) begin
      rd_word = win1_base;
    end
  end

  // write channel bookkeeping
  always_comb begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
    end
  end

  always_comb begin
    next_rvalid = s_axi_rvalid;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (rd_take) begin
      next_rvalid = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      wr_addr       <= '0;
      wr_data       <= '0;
      wr_strb       <= '0;
    end else begin
      aw_held       <= next_aw_held;
      w_held        <= next_w_held;
      s_axi_awready <= !next_aw_held;
      s_axi_wready  <= !next_w_held;
      if (s_axi_awvalid && s_axi_awready) begin
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
    end
  end

  // write response, unmapped offsets get an error
  always_ff @(posedge clock) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= addr_known(wr_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read channel, one cycle from address to data
  always_ff @(posedge clock) begin
    if (rst) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_rdata   <= ZERO_WORD;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_rvalid  <= next_rvalid;
      s_axi_arready <= !next_rvalid;
      if (rd_take) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= addr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // software-writable registers
  always_ff @(posedge clock) begin
    if (rst) begin
      mem0_tb   <= TB_RST;
      win1_tb   <= TB_RST;
      mem0_base <= MEM0_BASE_RST;
      win1_base <= WIN1_BASE_RST;
    end else if (do_write) begin
      if (wr_addr == OFF_MEM0_TB) begin
        mem0_tb <= lane_merge(mem0_tb, wr_data, wr_strb, mem0_tb_wmask);
      end else if (wr_addr == OFF_WIN1_TB) begin
        win1_tb <= lane_merge(win1_tb, wr_data, wr_strb, win1_tb_wmask);
      end else if (wr_addr == OFF_MEM0_BASE) begin
        mem0_base <= lane_merge(mem0_base, wr_data, wr_strb, mem0_cmask);
      end else if (wr_addr == OFF_WIN1_BASE) begin
        win1_base <= lane_merge(win1_base, wr_data, wr_strb, win1_cmask);
      end
    end
  end

  // setup fields ignore bus writes, load path only
  always_ff @(posedge clock) begin
    if (rst) begin
      mem0_at   <= AT_RST;
      mem0_pf   <= PF_RST;
      mem0_mask <= '0;
      win1_at   <= AT_RST;
      win1_pf   <= PF_RST;
      win1_mask <= '0;
      win1_en   <= WIN1_EN_RST;
    end else if (setup_load_writable) begin
      case (setup_load_sel)
        UWS_LOAD_MEM0: begin
          mem0_at   <= setup_load_data[SETUP_AT_MSB:SETUP_AT_LSB];
          mem0_pf   <= setup_load_data[SETUP_PF_BIT];
          mem0_mask <= setup_load_data[SETUP_MASK_MSB:MEM0_LOW_W];
        end
        default: begin
          // loader takes mask bits 30:6 straight from the load data
          win1_at   <= setup_load_data[SETUP_AT_MSB:SETUP_AT_LSB];
          win1_pf   <= setup_load_data[SETUP_PF_BIT];
          win1_mask <= setup_load_data[SETUP_MASK_MSB:WIN1_LOW_W];
          win1_en   <= setup_load_data[SETUP_EN_BIT];
        end
      endcase
    end
  end

  // memory 0 has priority when both windows overlap
  // memory 0 window always enabled
  assign hit0 = MEM0_EN_VALUE && win_match(up_addr, mem0_base, mem0_cmask);
  assign hit1 = win1_en && win_match(up_addr, win1_base, win1_cmask);

  // replace masked bits, pass the rest
  always_ff @(posedge clock) begin
    if (rst) begin
      fwd_valid    <= 1'b0;
      fwd_addr     <= ZERO_WORD;
      fwd_hit_mem0 <= 1'b0;
      fwd_hit_win1 <= 1'b0;
    end else begin
      fwd_valid    <= up_valid;
      fwd_hit_mem0 <= up_valid && hit0;
      fwd_hit_win1 <= up_valid && hit1 && !hit0;
      if (hit0) begin
        fwd_addr <= win_xlate(up_addr, mem0_tb, mem0_cmask);
      end else if (hit1) begin
        fwd_addr <= win_xlate(up_addr, win1_tb, win1_cmask);
      end else begin
        fwd_addr <= up_addr;
      end
    end
  end

endmodule

/* File: verification/upstream_window_setup_regs_tb_top.sv */
// self-checking bench for the upstream window register bank
// assumes AXI4-Lite access, load port and initiator model on one clock
`timescale 1ns/100ps

module upstream_window_setup_regs_tb_top
  import uws_pkg::*;
;
  logic          clock, rst, go, setup_load_writable;
  logic          s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic          s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic          s_axi_rvalid, s_axi_rready, up_valid, fwd_valid;
  logic          fwd_hit_mem0, fwd_hit_win1;
  logic [1:0]    s_axi_bresp, s_axi_rresp;
  logic [3:0]    s_axi_wstrb;
  logic [7:0]    s_axi_awaddr, s_axi_araddr;
  logic [31:0]   s_axi_wdata, s_axi_rdata, setup_load_data, up_addr;
  logic [31:0]   fwd_addr, ga;
  uws_load_sel_t setup_load_sel;
  int            n_mismatch, checks, cyc;
  logic [7:0]    ra [7] = '{OFF_MEM0_TB, OFF_MEM0_SETUP, OFF_WIN1_TB,
    OFF_WIN1_SETUP, OFF_CAP_HDR, OFF_MEM0_BASE, OFF_WIN1_BASE};
  logic [31:0]   rv [7] = '{32'h0, 32'h8000_0000, 32'h0, 32'h0,
    32'h0000_0005, 32'hFFFF_F000, 32'h0};

  uws_regs u_uws_regs (.*);
  uws_init_model u_uws_init_model (.*);

  always #10 clock = ~clock;

  task automatic finish_test();
    if (n_mismatch == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rdata", s_axi_rdata, ed);
    chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
  endtask

  task automatic ld(input uws_load_sel_t sel, input logic [31:0] d);
    @(posedge clock);
    setup_load_writable <= 1'b1;
    setup_load_sel <= sel;
    setup_load_data <= d;
    @(posedge clock);
    setup_load_writable <= 1'b0;
  endtask

  task automatic up(input logic [31:0] a, ea, input logic [1:0] eh);
    @(posedge clock);
    go <= 1'b1;
    ga <= a;
    @(posedge clock);
    go <= 1'b0;
    @(posedge clock);
    #1;
    chk("fwd_addr", fwd_addr, ea);
    chk("fwd_flags", {29'h0, fwd_valid, fwd_hit_mem0, fwd_hit_win1},
        {29'h0, 1'b1, eh});
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      finish_test();
    end
  end

  initial begin
    {clock, go, setup_load_writable, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ga, setup_load_data} = '0;
    s_axi_wstrb = 4'hF;
    setup_load_sel = UWS_LOAD_MEM0;
    rst = 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++)
      rd(ra[i], rv[i], RESP_OKAY);
    rd(8'h00, 32'h0, RESP_SLVERR);
    wr(8'h00, 32'hFFFF_FFFF, RESP_SLVERR);
    wr(OFF_MEM0_SETUP, 32'h0, RESP_OKAY);
    wr(OFF_WIN1_SETUP, 32'hFFFF_FFFF, RESP_OKAY);
    wr(OFF_CAP_HDR, 32'hFFFF_FFFF, RESP_OKAY);
    rd(OFF_MEM0_SETUP, 32'h8000_0000, RESP_OKAY);
    rd(OFF_WIN1_SETUP, 32'h0, RESP_OKAY);
    rd(OFF_CAP_HDR, 32'h0000_0005, RESP_OKAY);
    wr(OFF_MEM0_TB, 32'hFFFF_FFFF, RESP_OKAY);
    rd(OFF_MEM0_TB, 32'hFFFF_F000, RESP_OKAY);
    wr(OFF_WIN1_TB, 32'hFFFF_FFFF, RESP_OKAY);
    rd(OFF_WIN1_TB, 32'hFFFF_FFC0, RESP_OKAY);
    // lower two byte lanes only
    s_axi_wstrb <= 4'h3;
    wr(OFF_WIN1_TB, 32'h0000_0000, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(OFF_WIN1_TB, 32'hFFFF_0000, RESP_OKAY);
    wr(OFF_MEM0_BASE, 32'h0, RESP_OKAY);
    rd(OFF_MEM0_BASE, 32'h7FFF_F000, RESP_OKAY);
    ld(UWS_LOAD_MEM0, 32'h0000_0008);
    rd(OFF_MEM0_SETUP, 32'h8000_0008, RESP_OKAY);
    // mask 11:6 kept clear for a memory window
    ld(UWS_LOAD_WIN1, 32'hFFFF_000B);
    rd(OFF_WIN1_SETUP, 32'hFFFF_000A, RESP_OKAY);
    wr(OFF_WIN1_BASE, 32'hFFFF_FFFF, RESP_OKAY);
    rd(OFF_WIN1_BASE, 32'hFFFF_0000, RESP_OKAY);
    wr(OFF_WIN1_BASE, 32'h8001_0000, RESP_OKAY);
    wr(OFF_WIN1_TB, 32'h1234_0000, RESP_OKAY);
    up(32'h8001_ABCD, 32'h1234_ABCD, 2'b01);
    up(32'h9000_0000, 32'h9000_0000, 2'b00);
    up(32'h0000_0040, 32'h8000_0040, 2'b10);
    ld(UWS_LOAD_WIN1, 32'h7FFF_000B);
    up(32'h8001_ABCD, 32'h8001_ABCD, 2'b00);
    // second reset must restore every changed register
    @(posedge clock);
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++)
      rd(ra[i], rv[i], RESP_OKAY);
    up(32'h8001_ABCD, 32'h0001_ABCD, 2'b10);
    finish_test();
  end
endmodule

/* File: verification/uws_init_model.sv */
// upstream initiator model driving requests into the bank
// assumes the bench asks for one request cycle with go and ga
`timescale 1ns/100ps

module uws_init_model (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        go,
  input  wire logic [31:0] ga,
  output logic             up_valid,
  output logic [31:0]      up_addr
);
  always_ff @(posedge clock) begin
    up_valid <= go && !rst;
    // idle address toggles so stale values never look valid
    up_addr  <= rst ? 32'h0000_0000 : (go ? ga : ~up_addr);
  end
endmodule

/* File: verification/uws_regs_assertions.sv */
// port checker for the upstream window register bank
// assumes one clock, synchronous active high reset, bound by port name
`timescale 1ns/100ps

module uws_regs_checker
  import uws_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        up_valid,
  input wire logic [31:0] up_addr,
  input wire logic        fwd_valid,
  input wire logic [31:0] fwd_addr,
  input wire logic        fwd_hit_mem0,
  input wire logic        fwd_hit_win1
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_fwd_follow: assert property (up_valid |=> fwd_valid)
    else $error("fwd_valid missing after request");
  chk_fwd_quiet: assert property (!up_valid |=> !fwd_valid)
    else $error("fwd_valid without request");
  chk_hit_exclusive: assert property (!(fwd_hit_mem0 && fwd_hit_win1))
    else $error("both windows flagged");
  chk_miss_passes: assert property (fwd_valid && !fwd_hit_mem0
    && !fwd_hit_win1 |-> fwd_addr == $past(up_addr))
    else $error("miss address altered");
  chk_low_pass: assert property ((fwd_hit_win1 || fwd_hit_mem0)
    |-> fwd_addr[5:0] == $past(up_addr[5:0]))
    else $error("low address bits altered");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer missing");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |=> ##[0:1] s_axi_bvalid)
    else $error("write response missing");
  chk_cap_header: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr == OFF_CAP_HDR |=> s_axi_rdata[15:0] == 16'h0005)
    else $error("capability header wrong");
  chk_mem0_enable: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr == OFF_MEM0_SETUP
    |=> s_axi_rdata[31] && !s_axi_rdata[0])
    else $error("memory 0 setup enable or type wrong");

  cover property (fwd_hit_win1);
  cover property (fwd_hit_mem0);
  cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule

bind uws_regs uws_regs_checker u_uws_regs_checker (.*);
